// ### flash_array_model.sv
// Behavioural flash array answering the sequencer's array strobes
`default_nettype none
module flash_array_model
    import flash_spc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [11:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        erase,
    input  wire logic        write,
    output logic      [7:0]  rdata,
    output logic             verify_fail,
    input  wire logic        bad_en,
    input  wire logic [11:0] bad_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4095];
    // Non-blank fill so a missed erase or a stray write shows up
    initial
    begin
        for (int i = 0; i < 4096; i++)
        begin
            mem[i] = 8'h3c;
        end
        mem[PROTECT_ADDR] = 8'h02; // Protects block 1 only
    end
    assign rdata       = mem[addr];
    assign verify_fail = bad_en && (addr == bad_addr);
    always @(posedge clk)
    begin
        if (erase)
        begin
            for (int i = 0; i < 256; i++)
            begin
                mem[{addr[11:8], 8'(i)}] <= BLANK_VALUE;
            end
        end
        // Programming can only clear bits, as a real array does
        if (write)
        begin
            mem[addr] <= mem[addr] & wdata;
        end
    end
endmodule : flash_array_model
`default_nettype wire

// ### flash_self_program.sv
// Flash self-programming mode control and command sequencer
// How it works
// - Halt in self-programming mode launches the loaded flash command.
// - Halt released automatically when the running command finishes.
// - Maskable interrupts blocked while self-programming mode is set.
// - Interrupts stay pending; acknowledged once the mode is left.
// - Verify takes 6.8 ms per whole block, 27 us per byte.
// - Block erase of selected block ends 8.5 ms after halt.
// - Blank check of selected block ends 480 us after halt.
// - Byte write programs one byte, ends 150 us after halt.
// - Processor executes nothing while a command runs.
// - Data RAM untouched while a command runs.
// - Erased bytes read back as ff.
// - Port pins hold halt-mode states in self-programming mode.
// - External security ignored; writes stop on a protected block or a bit that needs setting.
// - Protect byte at 0081 copied to mode bits 2-6 after reset.
// - Mode select clears at reset; one means self-programming.
// - Mode register changes only via the unlock sequence.
// - Flash contents undefined if reset hits a write or erase.
// - Broken unlock leaves mode unchanged and sets the error flag.
// - Three-bit command selects verify, erase, blank check, write.
`default_nettype none
module flash_self_program
    import flash_spc_pkg::*;
#(
    parameter logic [CNT_W-1:0] VERIFY_BLOCK_CYC = VERIFY_BLOCK_CYCLES,
    parameter logic [CNT_W-1:0] ERASE_CYC        = ERASE_CYCLES,
    parameter logic [CNT_W-1:0] BLANK_CYC        = BLANK_CYCLES,
    parameter logic [CNT_W-1:0] WRITE_CYC        = WRITE_CYCLES
)(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    input  wire logic        CPU_HALT_EXEC,
    output logic             CPU_STALL,
    output logic             HALT_RELEASE,
    output logic             INT_BLOCK,
    output logic             PORT_HOLD,
    output logic             RAM_INHIBIT,
    output logic      [11:0] FLASH_ADDR,
    output logic      [7:0]  FLASH_WDATA,
    output logic             FLASH_ERASE,
    output logic             FLASH_WRITE,
    input  wire logic [7:0]  FLASH_RDATA,
    input  wire logic        FLASH_VERIFY_FAIL
);
    unlock_t          u_q;
    unlock_t          u_d;
    seq_t             s_q;
    logic [7:0]       val_q;
    logic             mode_q;
    logic [4:0]       prot_q;
    logic [2:0]       stat_q;
    logic [2:0]       cmd_q;
    logic [7:0]       ph_q;
    logic [7:0]       pl_q;
    logic [7:0]       ch_q;
    logic [7:0]       cl_q;
    logic [7:0]       wbuf_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] el_q;
    logic [11:0]      addr_q;
    logic [11:0]      end_q;
    logic             scan_q;
    logic             blocked_q;
    logic             unlock_err;
    logic             apply;

    wire        wr_unlock = REG_WR && REG_ADDR == ADDR_UNLOCK;
    wire        wr_status = REG_WR && REG_ADDR == ADDR_STATUS;
    wire        wr_mode   = REG_WR && REG_ADDR == ADDR_MODE;
    wire        wr_cmd    = REG_WR && REG_ADDR == ADDR_COMMAND;
    wire        run       = s_q == S_RUN;
    wire        launch    = s_q == S_IDLE && CPU_HALT_EXEC && mode_q;
    wire        finish    = run && cnt_q == CNT_W'(1);
    wire [3:0]  blk       = ph_q[3:0];
    // Bit i of the protect byte guards block i for blocks 0-4; external security has no say here
    wire        prot_hit  = blk < PROTECT_BLOCKS && prot_q[blk[2:0]];
    wire        whole_blk = pl_q == 8'h00 && cl_q == 8'hff;
    wire [8:0]  vbytes    = 9'(cl_q - pl_q) + 9'h001;
    wire [19:0] vcyc      = 20'(vbytes) * 20'(VERIFY_BYTE_CYCLES);
    wire [CNT_W-1:0] dur  =
        cmd_q == CMD_VERIFY ? (whole_blk ? VERIFY_BLOCK_CYC : CNT_W'(vcyc)) :
        cmd_q == CMD_ERASE  ? ERASE_CYC :
        cmd_q == CMD_BLANK  ? BLANK_CYC :
        cmd_q == CMD_WRITE  ? WRITE_CYC :
        CNT_W'(1);
    wire        ranged    = cmd_q == CMD_VERIFY || cmd_q == CMD_WRITE;
    wire [11:0] start_a   = ranged ? {blk, pl_q} : {blk, 8'h00};
    wire [11:0] end_a     = cmd_q == CMD_VERIFY ? {blk, cl_q} :
                            cmd_q == CMD_BLANK  ? {blk, 8'hff} : start_a;
    wire        wr_conf   = |(wbuf_q & ~FLASH_RDATA);
    wire        modifies  = cmd_q == CMD_ERASE || cmd_q == CMD_WRITE;
    wire        set_vc    = scan_q && ((cmd_q == CMD_BLANK && FLASH_RDATA != BLANK_VALUE)
                            || (cmd_q == CMD_VERIFY && FLASH_VERIFY_FAIL));
    wire        set_wep   = (launch && modifies && prot_hit)
                            || (scan_q && !blocked_q && cmd_q == CMD_WRITE && wr_conf);
    wire [7:0]  mode_rd   = {1'b0, prot_q, 1'b0, mode_q};
    wire [7:0]  rd_mux    =
        REG_ADDR == ADDR_STATUS   ? {5'h00, stat_q} :
        REG_ADDR == ADDR_MODE     ? mode_rd :
        REG_ADDR == ADDR_COMMAND  ? {5'h00, cmd_q} :
        REG_ADDR == ADDR_PTR_HIGH ? ph_q :
        REG_ADDR == ADDR_PTR_LOW  ? pl_q :
        REG_ADDR == ADDR_CMP_HIGH ? ch_q :
        REG_ADDR == ADDR_CMP_LOW  ? cl_q :
        REG_ADDR == ADDR_WBUF     ? wbuf_q : 8'h00;

    assign CPU_STALL    = run;
    assign RAM_INHIBIT  = run;
    assign HALT_RELEASE = finish;
    // Held interrupts stay latched in the core and are served once this drops
    assign INT_BLOCK    = mode_q;
    assign PORT_HOLD    = mode_q;
    assign FLASH_ADDR   = addr_q;
    assign FLASH_WDATA  = wbuf_q;
    assign FLASH_ERASE  = scan_q && !blocked_q && cmd_q == CMD_ERASE;
    assign FLASH_WRITE  = scan_q && !blocked_q && cmd_q == CMD_WRITE && !wr_conf;

    // Any peripheral store outside the expected step breaks the sequence
    always_comb
    begin
        u_d        = u_q;
        unlock_err = 1'b0;
        apply      = 1'b0;
        if (wr_unlock && REG_WDATA == UNLOCK_KEY)
        begin
            u_d = U_KEY;
        end
        else if (REG_WR)
        begin
            u_d = U_IDLE;
            case (u_q)
                U_IDLE: unlock_err = wr_mode;
                U_KEY:
                begin
                    u_d        = wr_mode ? U_VAL : U_IDLE;
                    unlock_err = !wr_mode;
                end
                U_VAL:
                begin
                    u_d        = (wr_mode && REG_WDATA == ~val_q) ? U_INV : U_IDLE;
                    unlock_err = u_d == U_IDLE;
                end
                U_INV:
                begin
                    apply      = wr_mode && REG_WDATA == val_q;
                    unlock_err = !apply;
                end
                default: u_d = U_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            u_q    <= U_IDLE;
            val_q  <= 8'h00;
            mode_q <= 1'b0;
        end
        else
        begin
            u_q <= u_d;
            if (u_q == U_KEY && wr_mode)
                val_q <= REG_WDATA;
            if (apply)
                mode_q <= REG_WDATA[MODE_SELECT_BIT];
        end
    end

    // Set beats a software clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            stat_q <= 3'h0;
        else
        begin
            stat_q[STAT_UNLOCK_ERR] <= unlock_err ||
                (stat_q[STAT_UNLOCK_ERR] && !(wr_status && !REG_WDATA[STAT_UNLOCK_ERR]));
            stat_q[STAT_VERIFY_ERR] <= set_vc ||
                (stat_q[STAT_VERIFY_ERR] && !(wr_status && !REG_WDATA[STAT_VERIFY_ERR]));
            stat_q[STAT_PROTECT_ERR] <= set_wep ||
                (stat_q[STAT_PROTECT_ERR] && !(wr_status && !REG_WDATA[STAT_PROTECT_ERR]));
        end
    end

    // Setup registers are frozen while the core is stalled
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cmd_q  <= 3'h0;
            ph_q   <= 8'h00;
            pl_q   <= 8'h00;
            ch_q   <= 8'h00;
            cl_q   <= 8'h00;
            wbuf_q <= 8'h00;
        end
        else if (!run)
        begin
            if (wr_cmd)
                cmd_q <= REG_WDATA[2:0];
            if (REG_WR && REG_ADDR == ADDR_PTR_HIGH)
                ph_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == ADDR_PTR_LOW)
                pl_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == ADDR_CMP_HIGH)
                ch_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == ADDR_CMP_LOW)
                cl_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == ADDR_WBUF)
                wbuf_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
            REG_RDATA <= rd_mux;
    end

    // Reset mid-erase leaves the array undefined; nothing here tries to recover
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s_q       <= S_LOAD;
            prot_q    <= 5'h00;
            addr_q    <= PROTECT_ADDR;
            end_q     <= 12'h000;
            cnt_q     <= '0;
            scan_q    <= 1'b0;
            blocked_q <= 1'b0;
        end
        else
        begin
            case (s_q)
                S_LOAD:
                begin
                    prot_q <= FLASH_RDATA[4:0];
                    s_q    <= S_IDLE;
                end
                S_IDLE:
                    if (launch)
                    begin
                        s_q       <= S_RUN;
                        cnt_q     <= dur;
                        addr_q    <= start_a;
                        end_q     <= end_a;
                        scan_q    <= cmd_q == CMD_VERIFY || cmd_q == CMD_ERASE
                                     || cmd_q == CMD_BLANK || cmd_q == CMD_WRITE;
                        blocked_q <= modifies && prot_hit;
                    end
                S_RUN:
                begin
                    cnt_q <= cnt_q - CNT_W'(1);
                    if (scan_q && addr_q != end_q)
                        addr_q <= addr_q + 12'h001;
                    else
                        scan_q <= 1'b0;
                    if (finish)
                        s_q <= S_IDLE;
                end
                default: s_q <= S_IDLE;
            endcase
        end
    end

    // Cycles spent in the run state, read only by the checks below
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            el_q <= '0;
        else if (launch)
            el_q <= '0;
        else if (run)
            el_q <= el_q + CNT_W'(1);
    end

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);

    launch_busy_a: assert property (launch |=> CPU_STALL && RAM_INHIBIT)
        else $error("halt in self-programming mode did not start a command");
    release_done_a: assert property (HALT_RELEASE |-> CPU_STALL ##1 !CPU_STALL)
        else $error("halt release not aligned with end of command");
    int_block_a: assert property (mode_q |-> INT_BLOCK && PORT_HOLD)
        else $error("interrupts or pins not held in self-programming mode");
    int_pending_a: assert property ($fell(mode_q) |-> !INT_BLOCK)
        else $error("interrupt block kept after leaving the mode");
    verify_time_a: assert property (HALT_RELEASE && cmd_q == CMD_VERIFY && whole_blk
        |-> el_q == VERIFY_BLOCK_CYC - CNT_W'(1))
        else $error("whole-block verify time wrong");
    erase_time_a: assert property (HALT_RELEASE && cmd_q == CMD_ERASE
        |-> el_q == ERASE_CYC - CNT_W'(1))
        else $error("erase time wrong");
    blank_time_a: assert property (HALT_RELEASE && cmd_q == CMD_BLANK
        |-> el_q == BLANK_CYC - CNT_W'(1))
        else $error("blank check time wrong");
    write_time_a: assert property (HALT_RELEASE && cmd_q == CMD_WRITE
        |-> el_q == WRITE_CYC - CNT_W'(1))
        else $error("byte write time wrong");
    mode_guard_a: assert property ($changed(mode_q) |-> $past(apply))
        else $error("mode changed outside the unlock sequence");
    unlock_err_a: assert property (u_q == U_IDLE && wr_mode && !wr_unlock
        |=> stat_q[STAT_UNLOCK_ERR] && $stable(mode_q))
        else $error("broken unlock not flagged");
    erase_strobe_a: assert property (launch && cmd_q == CMD_ERASE && !prot_hit
        |=> FLASH_ERASE ##1 !FLASH_ERASE)
        else $error("erase strobe missing");

    erase_done_c: cover property (HALT_RELEASE && cmd_q == CMD_ERASE);
    write_done_c: cover property (HALT_RELEASE && cmd_q == CMD_WRITE);
    unlock_ok_c: cover property (apply && REG_WDATA[MODE_SELECT_BIT]);
    unlock_bad_c: cover property (unlock_err);
endmodule : flash_self_program
`default_nettype wire

// ### flash_spc_pkg.sv
// Constants for the flash self-programming sequencer
`default_nettype none
package flash_spc_pkg;
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          CNT_W          = 19;
    localparam int          VERIFY_BLK_NS  = 6800000;
    localparam int          VERIFY_BYTE_NS = 27000;
    localparam int          ERASE_NS       = 8500000;
    localparam int          BLANK_NS       = 480000;
    localparam int          WRITE_NS       = 150000;
    localparam logic [CNT_W-1:0] VERIFY_BLOCK_CYCLES = CNT_W'(VERIFY_BLK_NS / CLK_PERIOD_NS);
    localparam logic [10:0] VERIFY_BYTE_CYCLES = 11'(VERIFY_BYTE_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ERASE_CYCLES = CNT_W'(ERASE_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] BLANK_CYCLES = CNT_W'(BLANK_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WRITE_CYCLES = CNT_W'(WRITE_NS / CLK_PERIOD_NS);
    // Register addresses
    localparam logic [15:0] ADDR_UNLOCK    = 16'hffa0;
    localparam logic [15:0] ADDR_STATUS    = 16'hffa1;
    localparam logic [15:0] ADDR_MODE      = 16'hffa2;
    localparam logic [15:0] ADDR_COMMAND   = 16'hffa3;
    localparam logic [15:0] ADDR_PTR_HIGH  = 16'hffa4;
    localparam logic [15:0] ADDR_PTR_LOW   = 16'hffa5;
    localparam logic [15:0] ADDR_CMP_HIGH  = 16'hffa6;
    localparam logic [15:0] ADDR_CMP_LOW   = 16'hffa7;
    localparam logic [15:0] ADDR_WBUF      = 16'hffa8;
    localparam logic [7:0]  UNLOCK_KEY     = 8'ha5;
    localparam logic [11:0] PROTECT_ADDR   = 12'h081;
    localparam logic [7:0]  BLANK_VALUE    = 8'hff;
    localparam logic [3:0]  PROTECT_BLOCKS = 4'h5;
    // Field positions
    localparam int          STAT_UNLOCK_ERR = 0;
    localparam int          STAT_VERIFY_ERR = 1;
    localparam int          STAT_PROTECT_ERR = 2;
    localparam int          MODE_SELECT_BIT = 0;
    localparam int          MODE_PROT_LSB   = 2;
    // Command codes
    localparam logic [2:0]  CMD_VERIFY     = 3'h1;
    localparam logic [2:0]  CMD_ERASE      = 3'h3;
    localparam logic [2:0]  CMD_BLANK      = 3'h4;
    localparam logic [2:0]  CMD_WRITE      = 3'h5;
    typedef enum logic [3:0] {
        U_IDLE = 4'b0001,
        U_KEY  = 4'b0010,
        U_VAL  = 4'b0100,
        U_INV  = 4'b1000
    } unlock_t;
    typedef enum logic [2:0] {
        S_LOAD = 3'b001,
        S_IDLE = 3'b010,
        S_RUN  = 3'b100
    } seq_t;
endpackage : flash_spc_pkg
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the flash self-programming sequencer
`default_nettype none
module tb_top
    import flash_spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [CNT_W-1:0] VBC = 19'd300;
    localparam logic [CNT_W-1:0] ERC = 19'd50;
    localparam logic [CNT_W-1:0] BLC = 19'd300;
    localparam logic [CNT_W-1:0] WRC = 19'd20;
    logic        CORE_CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic [15:0] REG_ADDR = 16'h0000;
    logic [7:0]  REG_WDATA = 8'h00;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic        CPU_HALT_EXEC = 1'b0;
    logic        bad_en = 1'b0;
    logic [11:0] bad_addr = 12'h000;
    wire  [7:0]  REG_RDATA, FLASH_WDATA, FLASH_RDATA;
    wire  [11:0] FLASH_ADDR;
    wire         CPU_STALL, HALT_RELEASE, INT_BLOCK, PORT_HOLD, RAM_INHIBIT;
    wire         FLASH_ERASE, FLASH_WRITE, FLASH_VERIFY_FAIL;
    logic [31:0] mismatches = 0, num_checks = 0, stall_cnt = 0, rel_at = 0;
    logic [31:0] rd_q[$], dur_q[$];
    logic        rd_prev = 1'b0;
    logic [7:0]  pl, wd;
    always #12.5 CORE_CLK = ~CORE_CLK;
    flash_self_program #(.VERIFY_BLOCK_CYC(VBC), .ERASE_CYC(ERC), .BLANK_CYC(BLC),
                         .WRITE_CYC(WRC)) flash_self_program_i (
        .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .CPU_HALT_EXEC(CPU_HALT_EXEC), .CPU_STALL(CPU_STALL), .HALT_RELEASE(HALT_RELEASE),
        .INT_BLOCK(INT_BLOCK), .PORT_HOLD(PORT_HOLD), .RAM_INHIBIT(RAM_INHIBIT),
        .FLASH_ADDR(FLASH_ADDR), .FLASH_WDATA(FLASH_WDATA), .FLASH_ERASE(FLASH_ERASE),
        .FLASH_WRITE(FLASH_WRITE), .FLASH_RDATA(FLASH_RDATA),
        .FLASH_VERIFY_FAIL(FLASH_VERIFY_FAIL));
    flash_array_model flash_array_model_i (
        .clk(CORE_CLK), .addr(FLASH_ADDR), .wdata(FLASH_WDATA), .erase(FLASH_ERASE),
        .write(FLASH_WRITE), .rdata(FLASH_RDATA), .verify_fail(FLASH_VERIFY_FAIL),
        .bad_en(bad_en), .bad_addr(bad_addr));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks != 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        rd_q.push_back({24'h0, exp});
        @(posedge CORE_CLK);
        REG_RD   <= 1'b0;
    endtask : rd
    // Key, value, inverse, value: only the last store lands
    task automatic unlock(input logic [7:0] v);
        wr(ADDR_UNLOCK, UNLOCK_KEY);
        wr(ADDR_MODE, v);
        wr(ADDR_MODE, ~v);
        wr(ADDR_MODE, v);
    endtask : unlock
    // Loads command and range, halts, waits out the stall, then reads and clears status
    task automatic run(input logic [2:0] cmd, input logic [7:0] ph, input logic [7:0] lo,
                       input logic [7:0] hi, input logic [31:0] n, input logic [7:0] st);
        int i;
        wr(ADDR_COMMAND, {5'h00, cmd});
        wr(ADDR_PTR_HIGH, ph);
        wr(ADDR_PTR_LOW, lo);
        wr(ADDR_CMP_HIGH, ph);
        wr(ADDR_CMP_LOW, hi);
        dur_q.push_back(n);
        @(posedge CORE_CLK);
        CPU_HALT_EXEC <= 1'b1;
        @(posedge CORE_CLK);
        CPU_HALT_EXEC <= 1'b0;
        // Bound is renewed per command, as a watchdog cleared before each halt
        for (i = 0; i < n + 10; i++)
        begin
            @(posedge CORE_CLK);
            if (CPU_STALL !== 1'b1)
                break;
        end
        if (i >= n + 10)
        begin
            mismatches++;
            finish_test();
        end
        rd(ADDR_STATUS, st);
        wr(ADDR_STATUS, 8'h00);
    endtask : run
    // Monitor: read answers and stall lengths are matched against queued notes
    always @(posedge CORE_CLK)
    begin
        if (rd_prev)
            check({24'h0, REG_RDATA}, rd_q.pop_front());
        rd_prev = (REG_RD === 1'b1);
        if (CPU_STALL === 1'b1)
        begin
            if (stall_cnt == 0)
                check({RAM_INHIBIT, INT_BLOCK, PORT_HOLD}, 3'b111);
            if (HALT_RELEASE === 1'b1)
                rel_at = stall_cnt + 1;
            stall_cnt = stall_cnt + 1;
        end
        else if (stall_cnt != 0)
        begin
            check(stall_cnt, dur_q.pop_front());
            check(rel_at, stall_cnt);
            stall_cnt = 0;
            rel_at = 0;
        end
    end
    initial
    begin
        void'($urandom(32'hbe10c27b));
        repeat (10) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        rd(ADDR_MODE, 8'h08);
        rd(ADDR_STATUS, 8'h00);
        wr(ADDR_MODE, 8'h01);
        rd(ADDR_STATUS, 8'h01);
        wr(ADDR_UNLOCK, UNLOCK_KEY);
        wr(16'h0010, 8'h00);
        wr(ADDR_MODE, 8'h01);
        rd(ADDR_MODE, 8'h08);
        rd(16'h0010, 8'h00);
        rd(ADDR_UNLOCK, 8'h00);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        @(posedge CORE_CLK);
        CPU_HALT_EXEC <= 1'b1;
        @(posedge CORE_CLK);
        CPU_HALT_EXEC <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        check(CPU_STALL, 1'b0);
        unlock(8'h01);
        rd(ADDR_MODE, 8'h09);
        repeat (640) @(posedge CORE_CLK);
        check({INT_BLOCK, PORT_HOLD}, 2'b11);
        pl = 8'($urandom) & 8'hfe;
        wd = 8'($urandom) & 8'hfe;
        run(CMD_ERASE, 8'h02, 8'h00, 8'hff, ERC, 8'h00);
        check(flash_array_model_i.mem[{4'h2, pl}], BLANK_VALUE);
        check(flash_array_model_i.mem[12'h2ff], BLANK_VALUE);
        run(CMD_BLANK, 8'h02, 8'h00, 8'hff, BLC, 8'h00);
        // Writing all ones must leave an erased byte blank and raise no error
        wr(ADDR_WBUF, 8'hff);
        run(CMD_WRITE, 8'h02, pl, pl, WRC, 8'h00);
        run(CMD_WRITE, 8'h02, pl, pl, WRC, 8'h00);
        check(flash_array_model_i.mem[{4'h2, pl}], 8'hff);
        wr(ADDR_WBUF, wd);
        run(CMD_WRITE, 8'h02, pl, pl, WRC, 8'h00);
        check(flash_array_model_i.mem[{4'h2, pl}], wd);
        run(CMD_BLANK, 8'h02, 8'h00, 8'hff, BLC, 8'h02);
        wr(ADDR_WBUF, ~wd);
        run(CMD_WRITE, 8'h02, pl, pl, WRC, 8'h04);
        check(flash_array_model_i.mem[{4'h2, pl}], wd);
        run(CMD_ERASE, 8'h01, 8'h00, 8'hff, ERC, 8'h04);
        check(flash_array_model_i.mem[12'h100], 8'h3c);
        run(CMD_VERIFY, 8'h02, pl, pl + 8'h01, 2 * VERIFY_BYTE_CYCLES, 8'h00);
        bad_addr <= {4'h2, pl + 8'h01};
        bad_en   <= 1'b1;
        run(CMD_VERIFY, 8'h02, pl, pl + 8'h01, 2 * VERIFY_BYTE_CYCLES, 8'h02);
        bad_en   <= 1'b0;
        run(CMD_VERIFY, 8'h02, 8'h00, 8'hff, VBC, 8'h00);
        run(3'h0, 8'h02, 8'h00, 8'hff, 1, 8'h00);
        unlock(8'h00);
        rd(ADDR_MODE, 8'h08);
        check({INT_BLOCK, PORT_HOLD}, 2'b00);
        repeat (5) @(posedge CORE_CLK);
        check(rd_q.size() + dur_q.size(), 0);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
